// ### src/auto_baud_detect.sv
// Purpose: Auto-baud measurement of a received sync character
// Assumes: Receive line is asynchronous; controls come from same clock
// Notes:   Enable and overflow flag are held here, set/clear by pulses
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module auto_baud_detect
    import autobaud_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        receive_line,
    input  wire logic        autobaud_enable_set,
    input  wire logic        autobaud_enable_clear,
    input  wire logic        overflow_clear,
    input  wire logic        wake_on_break_enable,
    input  wire logic        wide_divisor_select,
    input  wire logic        high_speed_select,
    input  wire logic        receive_data_read,
    input  wire logic        divisor_low_write,
    input  wire logic        divisor_high_write,
    input  wire logic [7:0]  divisor_wdata,
    output logic             autobaud_enable,
    output logic             autobaud_overflow_flag,
    output logic             receive_flag,
    output logic             receiver_hold_idle,
    output logic [7:0]       divisor_low,
    output logic [7:0]       divisor_high
);
    // =================================================================
    // Receive line synchroniser and edge detect
    logic       rx_meta_reg;
    logic       rx_sync_reg;
    logic       rx_prev_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= receive_line;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    // =================================================================
    // Single-cycle line edges
    wire rx_rise = rx_sync_reg & ~rx_prev_reg;
    wire rx_fall = ~rx_sync_reg & rx_prev_reg;

    // =================================================================
    // Wake-on-break gating
    wake_state_t wake_reg;
    wake_state_t wake_next;
    always_comb begin
        wake_next = wake_reg;
        case (wake_reg)
            WAKE_OFF: begin
                if (autobaud_enable_set && wake_on_break_enable)
                    wake_next = WAKE_WAIT_FALL;
            end
            WAKE_WAIT_FALL: begin
                if (!autobaud_enable) wake_next = WAKE_OFF;
                else if (rx_fall) wake_next = WAKE_WAIT_RISE;
            end
            WAKE_WAIT_RISE: begin
                if (!autobaud_enable || rx_rise) wake_next = WAKE_OFF;
            end
            default: wake_next = WAKE_OFF;
        endcase
    end
    wire wake_busy = (wake_reg != WAKE_OFF);

    // =================================================================
    // Auto-baud tick
    abd_state_t state_reg;
    abd_state_t state_next;
    wire        abd_tick;
    // Gated by enable so an abort stops counting and completion at once
    wire        measuring = (state_reg == ABD_MEASURE) &&
                            autobaud_enable;
    autobaud_tick_div u_div (
        .sys_clk             (sys_clk),
        .arst_n              (arst_n),
        .clear               (~measuring),
        .wide_divisor_select (wide_divisor_select),
        .high_speed_select   (high_speed_select),
        .tick                (abd_tick)
    );

    // =================================================================
    // Measurement sequence
    logic [2:0]  edges_reg;
    logic [15:0] count_reg;
    wire  done = measuring && rx_rise &&
                 (edges_reg == `ABD_EDGES_TOTAL - 3'd1);
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ABD_IDLE: begin
                if (autobaud_enable_set) state_next = ABD_WAIT_START;
            end
            ABD_WAIT_START: begin
                if (!autobaud_enable) state_next = ABD_IDLE;
                else if (!wake_busy && rx_fall) state_next = ABD_WAIT_FIRST;
            end
            ABD_WAIT_FIRST: begin
                if (!autobaud_enable) state_next = ABD_IDLE;
                else if (rx_rise) state_next = ABD_MEASURE;
            end
            ABD_MEASURE: begin
                if (!autobaud_enable || done) state_next = ABD_IDLE;
            end
            default: state_next = ABD_IDLE;
        endcase
    end
    wire start_count = (state_reg == ABD_WAIT_FIRST) && rx_rise &&
                       autobaud_enable;
    wire        count_step = measuring && abd_tick;
    wire        wrap       = count_step && (count_reg == 16'hffff);
    wire [15:0] count_next =
        start_count ? `ABD_COUNT_START :
        count_step  ? count_reg + 16'h0001 :
                      count_reg;
    wire [2:0] edges_next =
        start_count            ? 3'd1 :
        (measuring && rx_rise) ? edges_reg + 3'd1 : edges_reg;

    // =================================================================
    // Flags
    wire en_next  = autobaud_enable_set ? 1'b1 :
                    (done || autobaud_enable_clear) ? 1'b0 :
                    autobaud_enable;
    wire ovf_next = wrap ? 1'b1 :
                    (overflow_clear && !autobaud_enable) ? 1'b0 :
                    autobaud_overflow_flag;
    wire rcv_next = done ? 1'b1 :
                    receive_data_read ? 1'b0 : receive_flag;
    wire busy_next = (state_next != ABD_IDLE) || en_next;

    // =================================================================
    // Divisor byte writes, refused while calibration owns the counter
    wire        wr_low_ok  = !autobaud_enable && divisor_low_write;
    wire        wr_high_ok = !autobaud_enable && divisor_high_write &&
                             !divisor_low_write;
    wire [15:0] count_load =
        wr_low_ok  ? {count_reg[15:8], divisor_wdata} :
        wr_high_ok ? {divisor_wdata, count_reg[7:0]} : count_next;

    // =================================================================
    // Sequence state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ABD_IDLE;
            wake_reg  <= WAKE_OFF;
        end else begin
            state_reg <= state_next;
            wake_reg  <= wake_next;
        end
    end

    // =================================================================
    // Edge count and divisor pair
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edges_reg <= 3'd0;
            count_reg <= `ABD_DIVISOR_RESET;
        end else begin
            edges_reg <= edges_next;
            count_reg <= count_load;
        end
    end

    // =================================================================
    // Enable and overflow flags
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            autobaud_enable        <= 1'b0;
            autobaud_overflow_flag <= 1'b0;
        end else begin
            autobaud_enable        <= en_next;
            autobaud_overflow_flag <= ovf_next;
        end
    end

    // =================================================================
    // Receive flag and receiver hold
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            receive_flag       <= 1'b0;
            receiver_hold_idle <= 1'b0;
        end else begin
            receive_flag       <= rcv_next;
            receiver_hold_idle <= busy_next;
        end
    end

    // =================================================================
    // Divisor byte outputs
    assign divisor_low  = count_reg[7:0];
    assign divisor_high = count_reg[15:8];
endmodule // auto_baud_detect
`default_nettype wire

// ### src/autobaud_defines.svh
// Purpose: Constants for the auto-baud measurement unit
// Assumes: 100 MHz system clock is the oscillator
// Notes:   Dividers are in system clock cycles; counts are in auto-baud ticks
`ifndef AUTOBAUD_DEFINES_SVH
`define AUTOBAUD_DEFINES_SVH
// =====================================================================
// Auto-baud clock dividers
`define ABD_DIV_FAST      10'd32
`define ABD_DIV_MID       10'd128
`define ABD_DIV_SLOW      10'd512
// =====================================================================
// Counter and edge figures
`define ABD_COUNT_START   16'h0001
`define ABD_EDGES_TOTAL   3'd5
`define ABD_DIVISOR_RESET 16'h0000
`endif

// ### src/autobaud_pkg.sv
// Purpose: Types for the auto-baud measurement unit
// Assumes: Nothing
// Notes:   Constants live in autobaud_defines.svh
package autobaud_pkg;
    typedef enum logic [1:0] {
        ABD_IDLE,
        ABD_WAIT_START,
        ABD_WAIT_FIRST,
        ABD_MEASURE
    } abd_state_t;
    typedef enum logic [1:0] {
        WAKE_OFF,
        WAKE_WAIT_FALL,
        WAKE_WAIT_RISE
    } wake_state_t;
endpackage

// ### src/autobaud_tick_div.sv
// Purpose: Auto-baud clock enable generator
// Assumes: Single system clock
// Notes:   Divider restarts while clear is high
`timescale 1ns/1ps
`default_nettype none
`include "autobaud_defines.svh"
module autobaud_tick_div (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic clear,
    input  wire logic wide_divisor_select,
    input  wire logic high_speed_select,
    output logic      tick
);
    // =================================================================
    // Divide ratio select
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    wire  [9:0] ratio;
    wire        both_set = wide_divisor_select & high_speed_select;
    wire        one_set  = wide_divisor_select ^ high_speed_select;
    assign ratio = both_set ? `ABD_DIV_FAST :
                   one_set  ? `ABD_DIV_MID  : `ABD_DIV_SLOW;
    wire        wrap = (cnt_reg == ratio - 10'd1);
    assign cnt_next = (clear | wrap) ? 10'd0 : cnt_reg + 10'd1;
    // =================================================================
    // Counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 10'd0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= wrap & ~clear;
        end
    end
endmodule // autobaud_tick_div
`default_nettype wire

// ### verif/auto_baud_detect_monitor.sv
// Purpose: Port assertions for the auto-baud unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Overflow needs a very slow line; only asserted here
`timescale 1ns/1ps
`default_nettype none
module auto_baud_detect_monitor (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       autobaud_enable_set,
    input wire logic       autobaud_enable_clear,
    input wire logic       overflow_clear,
    input wire logic       receive_data_read,
    input wire logic       divisor_low_write,
    input wire logic       divisor_high_write,
    input wire logic       autobaud_enable,
    input wire logic       autobaud_overflow_flag,
    input wire logic       receive_flag,
    input wire logic       receiver_hold_idle,
    input wire logic [7:0] divisor_low,
    input wire logic [7:0] divisor_high
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire logic [15:0] count = {divisor_high, divisor_low};
    en_starts_a: assert property (autobaud_enable_set |=> autobaud_enable)
        else $error("enable not set");
    idle_hold_a: assert property (autobaud_enable |-> receiver_hold_idle)
        else $error("receiver not held idle");
    done_flag_a: assert property ($fell(autobaud_enable) &&
        !$past(autobaud_enable_clear) |-> receive_flag) else $error("no flag");
    count_kept_a: assert property (!autobaud_enable &&
        !autobaud_enable_set && !divisor_low_write && !divisor_high_write
        |=> $stable(count)) else $error("count not kept");
    read_clears_a: assert property (receive_data_read && !autobaud_enable
        |=> !receive_flag) else $error("flag not cleared");
    ovf_sticky_a: assert property (autobaud_overflow_flag &&
        !(overflow_clear && !autobaud_enable) |=> autobaud_overflow_flag)
        else $error("overflow flag lost");
    ovf_clear_a: assert property (overflow_clear && !autobaud_enable
        |=> !autobaud_overflow_flag) else $error("overflow not cleared");
    ovf_cause_a: assert property ($rose(autobaud_overflow_flag) |->
        $past(autobaud_enable) && count == 16'h0000) else $error("bad ovf");
    cover property ($fell(autobaud_enable) && receive_flag);
    cover property (autobaud_enable_clear && autobaud_enable);
    cover property (receive_data_read && receive_flag);
endmodule // auto_baud_detect_monitor
bind auto_baud_detect auto_baud_detect_monitor auto_baud_detect_monitor_i (.*);
`default_nettype wire

// ### verif/auto_baud_detect_tb_top.sv
// Purpose: Self-checking bench for the auto-baud unit
// Assumes: Sync sender model drives the receive line
// Notes:   Eight bit times sit half a tick off tick boundaries
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module auto_baud_detect_tb_top;
    logic        sys_clk = 1'h0, arst_n = 1'h0, go = 1'h0, rd = 1'h0;
    logic        en_set = 1'h0, en_clr = 1'h0, ovf_clr = 1'h0;
    logic        wake = 1'h0, wide = 1'h0, hs = 1'h0;
    logic        wl = 1'h0, wh = 1'h0;
    logic [7:0]  wd = 8'h00;
    logic [15:0] bc = 16'h0001;
    logic        line, busy, en, ovf, rf, hold;
    logic [7:0]  dl, dh;
    int          miscompares = 0, checked = 0, last = 0, v = 0, exp_q[$];
    always #5 sys_clk = ~sys_clk;
    auto_baud_detect auto_baud_detect_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .receive_line(line), .autobaud_enable_set(en_set),
        .autobaud_enable_clear(en_clr), .overflow_clear(ovf_clr),
        .wake_on_break_enable(wake), .wide_divisor_select(wide),
        .high_speed_select(hs), .receive_data_read(rd),
        .divisor_low_write(wl), .divisor_high_write(wh),
        .divisor_wdata(wd), .autobaud_enable(en),
        .autobaud_overflow_flag(ovf), .receive_flag(rf),
        .receiver_hold_idle(hold), .divisor_low(dl), .divisor_high(dh));
    sync_char_sender sync_char_sender_i (.sys_clk(sys_clk), .go(go),
        .with_break(wake), .bit_cycles(bc), .line(line), .busy(busy));
    task automatic report_and_stop;
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic run(input int sel, input int m, input logic brk);
        int dv, t, e;
        dv = (sel == 3) ? 32 : (sel == 0) ? 512 : 128;
        t = dv * (2 * m + 1) / 16;
        exp_q.push_back(1 + 8 * t / dv);
        {wide, hs} = sel[1:0];
        wake = brk;
        bc = t[15:0];
        en_set = 1'h1;
        @(negedge sys_clk);
        en_set = 1'h0;
        go = 1'h1;
        `CHK({en, hold}, 2'h3)
        @(negedge sys_clk);
        go = 1'h0;
        for (int k = 0; k < 50000 && rf !== 1'h1; k++) @(negedge sys_clk);
        e = exp_q.pop_front();
        last = e;
        `CHK(en, 1'h0)
        `CHK({dh, dl}, e[15:0])
        if (!wide) `CHK(dh == 8'h00, e < 256)
        `CHK(ovf, 1'h0)
        while (busy) @(negedge sys_clk);
        rd = 1'h1;
        @(negedge sys_clk);
        rd = 1'h0;
        `CHK({rf, hold}, 2'h0)
    endtask
    initial begin
        void'($urandom(81));
        repeat (5) @(negedge sys_clk);
        arst_n = 1'h1;
        @(negedge sys_clk);
        for (int s = 0; s < 4; s++)
            run(s, s % 2 ? 256 + $urandom % 8 : 2 + $urandom % 10, 1'h0);
        run(1, 3 + $urandom % 9, 1'h1);
        wake = 1'h0;
        bc = 16'h0040;
        en_set = 1'h1;
        @(negedge sys_clk);
        en_set = 1'h0;
        v = $urandom;
        wd = v[7:0];
        wl = 1'h1;
        @(negedge sys_clk);
        wl = 1'h0;
        go = 1'h1;
        `CHK({dh, dl}, last[15:0])
        @(negedge sys_clk);
        go = 1'h0;
        repeat (200) @(negedge sys_clk);
        en_clr = 1'h1;
        @(negedge sys_clk);
        en_clr = 1'h0;
        ovf_clr = 1'h1;
        @(negedge sys_clk);
        ovf_clr = 1'h0;
        `CHK({en, rf, ovf, hold}, 4'h0)
        while (busy) @(negedge sys_clk);
        `CHK(rf, 1'h0)
        wl = 1'h1;
        @(negedge sys_clk);
        wl = 1'h0;
        wd = v[15:8];
        wh = 1'h1;
        @(negedge sys_clk);
        wh = 1'h0;
        `CHK({dh, dl}, v[15:0])
        report_and_stop;
    end
    initial begin
        #850_000;
        miscompares++;
        report_and_stop;
    end
endmodule // auto_baud_detect_tb_top
`default_nettype wire

// ### verif/sync_char_sender.sv
// Purpose: Remote transmitter sending the 55h sync character
// Assumes: Line idles high; bit time given in system clocks
// Notes:   Optional break of 13 low bit times ahead of the sync
`timescale 1ns/1ps
`default_nettype none
module sync_char_sender (
    input  wire logic        sys_clk,
    input  wire logic        go,
    input  wire logic        with_break,
    input  wire logic [15:0] bit_cycles,
    output logic             line,
    output logic             busy
);
    localparam logic [9:0] FRAME = 10'h2aa;
    initial begin
        line = 1'h1;
        busy = 1'h0;
    end
    always @(posedge go) begin
        busy = 1'h1;
        if (with_break) begin
            line = 1'h0;
            repeat (13 * bit_cycles) @(negedge sys_clk);
            line = 1'h1;
            repeat (2 * bit_cycles) @(negedge sys_clk);
        end
        for (int i = 0; i < 10; i++) begin
            line = FRAME[i];
            repeat (bit_cycles) @(negedge sys_clk);
        end
        busy = 1'h0;
    end
endmodule // sync_char_sender
`default_nettype wire
